// ==== logic/iah_iack_handler.sv ====
// Bus-master side of the interrupt acknowledge cycle.
// Assumes a requester outside grants the bus; backplane inputs are asynchronous.
`timescale 1ns/1ns
`default_nettype none

module iah_iack_handler (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              req_valid,
    input  wire iah_pkg::iah_req_t req,
    output logic                   req_ready,
    output logic                   bus_want,
    input  wire logic              bus_grant,
    input  wire logic              as_n_in,
    input  wire logic              dtack_n_in,
    input  wire logic              berr_n_in,
    input  wire logic [31:0]       data_in,
    output iah_pkg::iah_drv_t      drv_out,
    output logic                   drv_oe,
    output logic                   done,
    output logic                   berr_seen,
    output logic [31:0]            status_id
);

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_GRANT,
        ST_SETUP,
        ST_AS_LOW,
        ST_ACK,
        ST_HOLD,
        ST_DS_UP,
        ST_END
    } iah_state_t;

    ////////////////////////////////////////////////////////////////////////////

    logic as_s;
    logic dtack_s;
    logic berr_s;

    iah_sync #(
        .W(3)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .d       ({as_n_in, dtack_n_in, berr_n_in}),
        .q       ({as_s, dtack_s, berr_s})
    );

    ////////////////////////////////////////////////////////////////////////////

    iah_state_t                     state_reg,  state_next;
    iah_pkg::iah_req_t              req_reg,    req_next;
    iah_pkg::iah_drv_t              drv_reg,    drv_next;
    logic                           oe_reg,     oe_next;
    logic                           want_reg,   want_next;
    logic                           ready_reg,  ready_next;
    logic                           done_reg,   done_next;
    logic                           berr_reg,   berr_next;
    logic [31:0]                    sid_reg,    sid_next;
    logic [iah_pkg::CNT_W-1:0]      phase_reg,  phase_next;
    logic [iah_pkg::CNT_W-1:0]      as_hi_reg,  as_hi_next;
    logic [iah_pkg::CNT_W-1:0]      as_lo_reg,  as_lo_next;
    logic [iah_pkg::CNT_W-1:0]      ds_hi_reg,  ds_hi_next;
    logic                           ack_seen;

    assign ack_seen = !dtack_s || !berr_s;

    function automatic logic [iah_pkg::CNT_W-1:0] sat_inc(
        input logic [iah_pkg::CNT_W-1:0] v
    );
        return (v == iah_pkg::CNT_MAX) ? v : v + 1'b1;
    endfunction

    function automatic iah_pkg::iah_drv_t start_drv(input iah_pkg::iah_req_t r);
        iah_pkg::iah_drv_t d;
        d         = iah_pkg::DRV_IDLE;
        d.iack_n  = 1'b0;
        d.level   = r.level;
        d.lword_n = (r.width != iah_pkg::IAH_W_QUAD);
        return d;
    endfunction

    always_comb begin
        state_next = state_reg;
        req_next   = req_reg;
        drv_next   = drv_reg;
        oe_next    = oe_reg;
        want_next  = want_reg;
        done_next  = 1'b0;
        berr_next  = berr_reg;
        sid_next   = sid_reg;
        phase_next = sat_inc(phase_reg);
        as_hi_next = as_s ? sat_inc(as_hi_reg) : '0;
        as_lo_next = (oe_reg && !drv_reg.as_n) ? sat_inc(as_lo_reg) : '0;
        ds_hi_next = (oe_reg && drv_reg.ds0_n && drv_reg.ds1_n) ? sat_inc(ds_hi_reg) : '0;
        case (state_reg)
            ST_IDLE: begin
                if (req_valid && ready_reg) begin
                    req_next   = req;
                    want_next  = 1'b1;
                    state_next = ST_GRANT;
                end
            end
            ST_GRANT: begin
                // wait for grant and released AS
                if (bus_grant && as_s) begin
                    drv_next   = start_drv(req_reg);
                    oe_next    = 1'b1;
                    phase_next = '0;
                    state_next = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // address setup and AS high gap
                if (phase_reg >= iah_pkg::ADDR_SETUP_CYC - 1'b1 &&
                    as_hi_reg >= iah_pkg::AS_TAKE_CYC - 1'b1 &&
                    as_hi_reg >= iah_pkg::AS_GAP_CYC - 1'b1) begin
                    drv_next.as_n = 1'b0;
                    phase_next    = '0;
                    state_next    = ST_AS_LOW;
                end
            end
            ST_AS_LOW: begin
                if (dtack_s && berr_s &&
                    ds_hi_reg >= iah_pkg::DS_GAP_CYC - 1'b1 &&
                    ds_hi_reg >= iah_pkg::WRITE_SETUP_CYC - 1'b1) begin
                    drv_next.ds0_n = 1'b0;
                    // second strobe in the same cycle
                    drv_next.ds1_n = (req_reg.width == iah_pkg::IAH_W_BYTE);
                    state_next     = ST_ACK;
                end
            end
            ST_ACK: begin
                if (ack_seen) begin
                    berr_next  = dtack_s;
                    phase_next = '0;
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // strobe and AS held past answer
                if (phase_reg >= iah_pkg::DS_HOLD_CYC - 1'b1 &&
                    as_lo_reg >= iah_pkg::AS_MIN_CYC - 1'b1) begin
                    // Data sampled late, after the read data settles
                    case (req_reg.width)
                        iah_pkg::IAH_W_BYTE:   sid_next = {24'h000000, data_in[7:0]};
                        iah_pkg::IAH_W_DOUBLE: sid_next = {16'h0000, data_in[15:0]};
                        default:               sid_next = data_in;
                    endcase
                    drv_next.ds0_n = 1'b1;
                    drv_next.ds1_n = 1'b1;
                    phase_next     = '0;
                    state_next     = ST_DS_UP;
                end
            end
            ST_DS_UP: begin
                if (phase_reg >= iah_pkg::WRITE_HOLD_CYC - 1'b1) begin
                    drv_next.as_n = 1'b1;
                    done_next     = 1'b1;
                    state_next    = ST_END;
                end
            end
            ST_END: begin
                // Back-to-back request keeps the bus
                if (req_valid && ready_reg) begin
                    req_next   = req;
                    drv_next   = start_drv(req);
                    phase_next = '0;
                    state_next = ST_SETUP;
                end else begin
                    drv_next   = iah_pkg::DRV_IDLE;
                    oe_next    = 1'b0;
                    want_next  = 1'b0;
                    state_next = ST_IDLE;
                end
            end
            default: begin
                drv_next   = iah_pkg::DRV_IDLE;
                oe_next    = 1'b0;
                want_next  = 1'b0;
                state_next = ST_IDLE;
            end
        endcase
        ready_next = (state_next == ST_IDLE) || (state_next == ST_END);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            req_reg   <= iah_pkg::REQ_RESET;
            drv_reg   <= iah_pkg::DRV_IDLE;
            oe_reg    <= 1'b0;
            want_reg  <= 1'b0;
            ready_reg <= 1'b1;
            done_reg  <= 1'b0;
            berr_reg  <= 1'b0;
            sid_reg   <= 32'h00000000;
            phase_reg <= '0;
            as_hi_reg <= '0;
            as_lo_reg <= '0;
            ds_hi_reg <= '0;
        end else begin
            state_reg <= state_next;
            req_reg   <= req_next;
            drv_reg   <= drv_next;
            oe_reg    <= oe_next;
            want_reg  <= want_next;
            ready_reg <= ready_next;
            done_reg  <= done_next;
            berr_reg  <= berr_next;
            sid_reg   <= sid_next;
            phase_reg <= phase_next;
            as_hi_reg <= as_hi_next;
            as_lo_reg <= as_lo_next;
            ds_hi_reg <= ds_hi_next;
        end
    end

    assign req_ready = ready_reg;
    assign bus_want  = want_reg;
    assign drv_out   = drv_reg;
    assign drv_oe    = oe_reg;
    assign done      = done_reg;
    assign berr_seen = berr_reg;
    assign status_id = sid_reg;

    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    a_drive_after_as: assert property ($rose(oe_reg) |-> $past(as_s))
        else $error("lines driven while AS still low");
    a_drive_after_grant: assert property ($rose(oe_reg) |-> $past(bus_grant))
        else $error("lines driven without grant");
    a_as_takeover_gap: assert property (
        $fell(drv_reg.as_n) |-> $past(as_hi_reg) >= 4'h5)
        else $error("AS driven low too soon after takeover");
    a_addr_setup: assert property (
        $fell(drv_reg.as_n) |-> $past(oe_reg, 4) && !$past(drv_reg.iack_n, 4)
                                && $past(drv_reg.level, 4) == drv_reg.level)
        else $error("IACK or level not set up before AS");
    a_as_high_gap: assert property (
        $fell(drv_reg.as_n) |-> $past(drv_reg.as_n, 4))
        else $error("AS high gap too short");
    a_ds_ack_idle: assert property ($fell(drv_reg.ds0_n) |-> $past(dtack_s && berr_s))
        else $error("strobe while answer lines low");
    a_as_before_ds: assert property (
        $fell(drv_reg.ds0_n) |-> !$past(drv_reg.as_n))
        else $error("strobe before AS");
    a_ds_high_gap: assert property (
        $fell(drv_reg.ds0_n) |-> $past(drv_reg.ds0_n && drv_reg.ds1_n, 4)
                                 && $past(drv_reg.write_n, 4))
        else $error("strobes or WRITE not high long enough");
    // WRITE is always high, so the drive window is what can break
    a_write_setup: assert property (
        $fell(drv_reg.ds0_n) |-> drv_reg.write_n && $past(oe_reg, 4)
                                 && $past(drv_reg.write_n, 3))
        else $error("WRITE not high before strobe");
    a_dsb_with_dsa: assert property (
        $fell(drv_reg.ds0_n) && req_reg.width != iah_pkg::IAH_W_BYTE
        |-> !drv_reg.ds1_n)
        else $error("second strobe late");
    a_code_held: assert property (
        oe_reg && !drv_reg.ds0_n && !ack_seen && state_reg == ST_ACK
        |=> $stable(drv_reg.level) && $stable(drv_reg.lword_n))
        else $error("level code changed before answer");
    a_iack_held: assert property (
        state_reg == ST_ACK && !ack_seen |=> !drv_reg.iack_n && !drv_reg.as_n)
        else $error("IACK or AS released before answer");
    a_as_min_low: assert property ($fell(drv_reg.as_n) |=> !drv_reg.as_n [*3])
        else $error("AS low too short");
    a_strobes_held: assert property (
        state_reg == ST_ACK && !ack_seen
        |=> !drv_reg.ds0_n && drv_reg.ds1_n == $past(drv_reg.ds1_n))
        else $error("strobe released before answer");
    a_dsb_held: assert property (
        state_reg == ST_ACK && !ack_seen && !drv_reg.ds1_n |=> !drv_reg.ds1_n)
        else $error("second strobe released early");
    a_ds_after_ack: assert property (
        state_reg == ST_ACK && ack_seen |=> !drv_reg.ds0_n [*3])
        else $error("strobe released too soon after answer");
    a_write_hold: assert property (
        $rose(drv_reg.ds0_n) |-> oe_reg && drv_reg.write_n ##1 oe_reg && drv_reg.write_n)
        else $error("WRITE not held after strobes");

    c_done_ok: cover property ($rose(done_reg) && !berr_reg);
    c_done_berr: cover property ($rose(done_reg) && berr_reg);
    c_quad: cover property ($fell(drv_reg.ds0_n) && !drv_reg.lword_n);
    c_back_to_back: cover property (state_reg == ST_END ##1 state_reg == ST_SETUP);

endmodule

`default_nettype wire

// ==== logic/iah_pkg.sv ====
// Shared types and timing constants for the interrupt acknowledge handler.
// Assumes a single 100 MHz system clock; all bus times are converted here.
`default_nettype none

package iah_pkg;

    localparam int CLK_PERIOD_NS = 10;

    // Bus minimums in nanoseconds
    localparam int AS_TAKE_NS     = 60;
    localparam int ADDR_SETUP_NS  = 35;
    localparam int AS_GAP_NS      = 40;
    localparam int DS_GAP_NS      = 40;
    localparam int WRITE_SETUP_NS = 35;
    localparam int AS_MIN_NS      = 40;
    localparam int DS_HOLD_NS     = 25;
    localparam int WRITE_HOLD_NS  = 10;

    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] CNT_MAX = 4'hF;

    // Least times round up to whole cycles
    localparam logic [CNT_W-1:0] AS_TAKE_CYC =
        CNT_W'((AS_TAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] ADDR_SETUP_CYC =
        CNT_W'((ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] AS_GAP_CYC =
        CNT_W'((AS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DS_GAP_CYC =
        CNT_W'((DS_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WRITE_SETUP_CYC =
        CNT_W'((WRITE_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] AS_MIN_CYC =
        CNT_W'((AS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] DS_HOLD_CYC =
        CNT_W'((DS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] WRITE_HOLD_CYC =
        CNT_W'((WRITE_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        IAH_W_BYTE,
        IAH_W_DOUBLE,
        IAH_W_QUAD
    } iah_width_t;

    typedef struct packed {
        logic [2:0] level;
        iah_width_t width;
    } iah_req_t;

    // Levels driven onto the backplane, all active low except level
    typedef struct packed {
        logic       iack_n;
        logic [2:0] level;
        logic       lword_n;
        logic       write_n;
        logic       ds1_n;
        logic       ds0_n;
        logic       as_n;
    } iah_drv_t;

    localparam iah_drv_t DRV_IDLE = '{iack_n: 1'b1, level: 3'h0, lword_n: 1'b1,
                                      write_n: 1'b1, ds1_n: 1'b1, ds0_n: 1'b1,
                                      as_n: 1'b1};
    localparam iah_req_t REQ_RESET = '{level: 3'h0, width: IAH_W_BYTE};

endpackage

`default_nettype wire

// ==== logic/iah_sync.sv ====
// Two-stage synchroniser for asynchronous backplane levels.
// Assumes the inputs may change at any time relative to clk_sys.
`timescale 1ns/1ns
`default_nettype none

module iah_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;

    // Inputs idle high, so reset to the released level
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_reg <= {W{1'b1}};
            q        <= {W{1'b1}};
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ==== tb/iah_intr_model.sv ====
// Behavioural responding interrupter plus bus timer on the backplane side.
// Assumes drv_out carries meaning only while drv_oe is high; pull-ups otherwise.
`timescale 1ns/1ns
`default_nettype none

module iah_intr_model #(
    parameter int TMO = 20
) (
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire iah_pkg::iah_drv_t drv_out,
    input  wire logic              drv_oe,
    input  wire logic [7:0][31:0]  id_tab,
    input  wire logic [2:0]        berr_level,
    output logic                   dtack_n,
    output logic                   berr_n,
    output logic [31:0]            data
);
    int   wait_cnt;
    logic busy;
    logic [31:0] id;

    assign id = id_tab[drv_out.level];

    ////////////////////////////////////////////////////////////////////////////
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dtack_n <= 1'h1;
            berr_n <= 1'h1;
            data <= 32'h0;
            busy <= 1'h0;
            wait_cnt <= 0;
        end else if (!busy) begin
            // Released data bus keeps moving so stale values never match
            data <= ~data;
            if (drv_oe && !drv_out.ds0_n) begin
                busy <= 1'h1;
                // no answer before 30 ns, timer error after 200 ns
                wait_cnt <= (drv_out.level == berr_level) ? TMO : $urandom_range(8, 3);
            end
        end else if (wait_cnt > 1) begin
            wait_cnt <= wait_cnt - 1;
        end else if (wait_cnt == 1) begin
            wait_cnt <= 0;
            if (drv_out.level == berr_level) begin
                berr_n <= 1'h0;
            end else begin
                dtack_n <= 1'h0;
                // Unused upper bytes held high, never low
                if (!drv_out.lword_n) data <= id;
                else if (!drv_out.ds1_n) data <= {16'hFFFF, id[15:0]};
                else data <= {24'hFFFFFF, id[7:0]};
            end
        end else if (!drv_oe || (drv_out.ds0_n && drv_out.ds1_n)) begin
            // answer held until both strobes high
            dtack_n <= 1'h1;
            berr_n <= 1'h1;
            busy <= 1'h0;
            data <= ~data;
        end
    end
endmodule

`default_nettype wire

// ==== tb/test_iack_cycle_handler_timing.sv ====
// Self-checking bench for the acknowledge handler with arbiter and prior owner.
// Assumes the far side is iah_intr_model; grant follows bus_want by one cycle while gnt_en is set.
`timescale 1ns/1ns
`default_nettype none

module test_iack_cycle_handler_timing;
    typedef struct { logic [2:0] lv; iah_pkg::iah_width_t w; } iah_exp_t;

    logic              clk_sys, rst, req_valid, bus_grant, gnt_en, prev_as_n;
    logic              req_ready, bus_want, drv_oe, done, berr_seen, as_n_bp;
    logic              dtack_n, berr_n;
    iah_pkg::iah_req_t req;
    iah_pkg::iah_drv_t drv_out, pd;
    logic [31:0]       status_id, data_in;
    logic [7:0][31:0]  id_tab;
    logic [2:0]        berr_level;
    logic              poe, first_as;
    int                miscompares, checks, cyc, i, seed_v;
    int                oe_cnt, as_hi, ds_hi, as_lo, ack_lo;
    iah_exp_t          exp_q[$];

    assign as_n_bp = drv_oe ? drv_out.as_n : prev_as_n;

    iah_iack_handler iah_iack_handler_inst (.clk_sys(clk_sys), .rst(rst),
        .req_valid(req_valid), .req(req), .req_ready(req_ready), .bus_want(bus_want),
        .bus_grant(bus_grant), .as_n_in(as_n_bp), .dtack_n_in(dtack_n), .berr_n_in(berr_n),
        .data_in(data_in), .drv_out(drv_out), .drv_oe(drv_oe), .done(done),
        .berr_seen(berr_seen), .status_id(status_id));

    iah_intr_model iah_intr_model_inst (.clk_sys(clk_sys), .rst(rst), .drv_out(drv_out),
        .drv_oe(drv_oe), .id_tab(id_tab), .berr_level(berr_level), .dtack_n(dtack_n),
        .berr_n(berr_n), .data(data_in));

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
        checks++;
        if (seen !== expv) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic test_done;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [31:0] want_id(input logic [31:0] id, input iah_pkg::iah_width_t w);
        case (w)
            iah_pkg::IAH_W_QUAD:   want_id = id;
            iah_pkg::IAH_W_DOUBLE: want_id = {16'h0000, id[15:0]};
            default:               want_id = {24'h000000, id[7:0]};
        endcase
    endfunction

    task automatic send(input logic [2:0] lv, input iah_pkg::iah_width_t w, input logic last);
        int n;
        req <= '{level: lv, width: w};
        req_valid <= 1'h1;
        exp_q.push_back('{lv: lv, w: w});
        for (n = 0; n < 2000; n++) begin
            @(posedge clk_sys);
            if (req_ready === 1'h1) break;
        end
        if (n == 2000) begin
            miscompares++;
            test_done();
        end
        // Valid stays up between back-to-back requests
        if (last) req_valid <= 1'h0;
    endtask

    task automatic wait_idle;
        int n;
        for (n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge clk_sys);
        if (exp_q.size() > 0) begin
            miscompares++;
            test_done();
        end
        repeat (4) @(posedge clk_sys);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        bus_grant <= bus_want && gnt_en;
        cyc++;
        if (cyc > 60000) begin
            miscompares++;
            test_done();
        end
    end

    // Backplane watcher; counters count sampled cycles before this edge
    always @(posedge clk_sys) begin
        if (!rst) begin
            if (drv_oe && !poe) begin
                chk(bus_grant, 1'h1);
                chk(prev_as_n, 1'h1);
                first_as = 1'h1;
            end
            if (drv_oe) begin
                chk(drv_out.write_n, 1'h1);
                if (!drv_out.as_n && pd.as_n) begin
                    chk(oe_cnt >= 4, 1'h1);
                    chk(as_hi >= (first_as ? 6 : 4), 1'h1);
                    first_as = 1'h0;
                end
                if (!drv_out.as_n && ack_lo == 0) begin
                    chk(drv_out.iack_n, 1'h0);
                    chk(drv_out.level, exp_q[0].lv);
                    chk(drv_out.lword_n, exp_q[0].w != iah_pkg::IAH_W_QUAD);
                end
                if (!drv_out.ds0_n && pd.ds0_n) begin
                    chk(pd.as_n, 1'h0);
                    chk(ds_hi >= 4, 1'h1);
                    chk(oe_cnt >= 4, 1'h1);
                    chk(dtack_n & berr_n, 1'h1);
                    chk(drv_out.ds1_n, exp_q[0].w == iah_pkg::IAH_W_BYTE);
                end
                if (drv_out.ds0_n && !pd.ds0_n) chk(ack_lo >= 3, 1'h1);
                if (drv_out.ds1_n && !pd.ds1_n) chk(ack_lo >= 1, 1'h1);
                if (drv_out.as_n && !pd.as_n) chk(as_lo >= 4 && ack_lo >= 1, 1'h1);
            end
            if (done === 1'h1) begin
                chk(berr_seen, exp_q[0].lv == berr_level);
                if (exp_q[0].lv != berr_level)
                    chk(status_id, want_id(id_tab[exp_q[0].lv], exp_q[0].w));
                void'(exp_q.pop_front());
            end
            oe_cnt = drv_oe ? oe_cnt + 1 : 0;
            as_hi = as_n_bp ? as_hi + 1 : 0;
            ds_hi = (drv_oe && drv_out.ds0_n && drv_out.ds1_n) ? ds_hi + 1 : 0;
            as_lo = (drv_oe && !drv_out.as_n) ? as_lo + 1 : 0;
            ack_lo = (!dtack_n || !berr_n) ? ack_lo + 1 : 0;
        end
        pd = drv_out;
        poe = drv_oe;
    end

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'h1;
        req_valid = 1'h0;
        req = iah_pkg::REQ_RESET;
        gnt_en = 1'h1;
        prev_as_n = 1'h1;
        berr_level = 3'h6;
        seed_v = $urandom(67153);
        for (i = 0; i < 8; i++) id_tab[i] = $urandom();
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        chk(drv_oe, 1'h0);
        chk(bus_want, 1'h0);
        chk(req_ready, 1'h1);
        chk(status_id, 32'h0);
        // Takeover while the previous owner still holds AS low
        prev_as_n <= 1'h0;
        send(3'h1, iah_pkg::IAH_W_BYTE, 1'h1);
        repeat (10) @(posedge clk_sys);
        chk(drv_oe, 1'h0);
        prev_as_n <= 1'h1;
        wait_idle();
        // Grant withheld: nothing may be driven
        gnt_en <= 1'h0;
        send(3'h2, iah_pkg::IAH_W_DOUBLE, 1'h1);
        repeat (15) @(posedge clk_sys);
        chk(drv_oe, 1'h0);
        gnt_en <= 1'h1;
        wait_idle();
        // Levels 1 to 7 back to back, all widths, level 6 ends by bus error
        for (i = 1; i < 8; i++)
            send(3'(i), iah_pkg::iah_width_t'(i % 3), i == 7);
        wait_idle();
        repeat (6) begin
            send(3'($urandom_range(7, 1)), iah_pkg::iah_width_t'($urandom_range(2, 0)), 1'h0);
            send(3'($urandom_range(7, 1)), iah_pkg::iah_width_t'($urandom_range(2, 0)), 1'h1);
            wait_idle();
        end
        test_done();
    end
endmodule

`default_nettype wire
